// >>> common/dcsf_pkg.sv
// Shared constants and types of the dual channel converter frame control
package dcsf_pkg;

	// ********************************************************
	// Widths
	// ********************************************************
	localparam int RESULT_W = 10;
	localparam int CTRL_W = 8;
	localparam int CNT_W = 5;

	// ********************************************************
	// Edge counts within one conversion
	// ********************************************************
	localparam logic [CNT_W-1:0] CONV_EDGES = 5'h10;
	localparam logic [CNT_W-1:0] TRACK_EDGES = 5'h03;
	localparam logic [CNT_W-1:0] HOLD_EDGE = 5'h04;
	localparam logic [CNT_W-1:0] LAST_BIT_EDGE = 5'h0d;
	localparam logic [CNT_W-1:0] CTRL_EDGES = 5'h08;
	localparam logic [CNT_W-1:0] FIRST_EDGE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;

	// ********************************************************
	// Control word fields
	// ********************************************************
	localparam int CHAN_ADDR_LOW_POS = 3;
	localparam int CHAN_ADDR_MID_POS = 4;
	localparam int CHAN_ADDR_TOP_POS = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
	localparam logic CHAN_RESET = 1'b0;

	// ********************************************************
	// Conversion phases
	// ********************************************************
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_TRACK = 4'b0010,
		PH_HOLD = 4'b0100,
		PH_NAP = 4'b1000
	} dcsf_phase_t;

endpackage

// >>> dv/dcsf_host.sv
// Host serial master model that frames conversions into the block
`timescale 1ns/1ps
`default_nettype none

module dcsf_host (
	input wire logic clock, // System clock
	input wire logic go, // Start one frame
	input wire logic idle_high, // Serial clock rest level
	input wire logic [1:0] n_conv, // Conversions per frame
	input wire logic [7:0] w0, // Control word, first conversion
	input wire logic [7:0] w1, // Control word, second conversion
	input wire logic dout_pin, // Resolved data output pin
	output logic sclk, // Serial clock
	output logic cs_n, // Chip select, active low
	output logic din, // Serial data to the block
	output logic busy, // Frame in progress
	output logic [15:0] rx0, // Word read, first conversion
	output logic [15:0] rx1 // Word read, second conversion
);
	logic [7:0] w;

	// One frame per request; clock stands still outside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		busy = 1'b0;
		forever begin
			@(negedge clock);
			if (go && !busy) begin
				busy = 1'b1;
				sclk = idle_high;
				repeat (8) @(negedge clock);
				cs_n = 1'b0;
				if (idle_high) begin
					// Clock high: first real fall follows later
					repeat (8) @(negedge clock);
				end
				for (int i = 0; i < 16 * n_conv; i++) begin
					w = (i < 16) ? w0 : w1;
					sclk = 1'b0;
					// Word bits first, then a toggling pattern
					din = (i % 16 < 8) ? w[7 - i % 16] : ~din;
					repeat (8) @(negedge clock);
					if (i < 16) begin
						rx0[15 - i] = dout_pin;
					end else begin
						rx1[15 - i % 16] = dout_pin;
					end
					sclk = 1'b1;
					repeat (8) @(negedge clock);
				end
				sclk = idle_high;
				repeat (8) @(negedge clock);
				cs_n = 1'b1;
				din = ~din;
				repeat (8) @(negedge clock);
				busy = 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the converter frame control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import dcsf_pkg::*;
	localparam logic [RESULT_W-1:0] RES_ONE = 10'h15a;
	localparam logic [RESULT_W-1:0] RES_TWO = 10'h2a5;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic idle_high = 1'b0;
	logic [1:0] n_conv = 2'h2;
	logic [7:0] w0 = 8'h00;
	logic [7:0] w1 = 8'h00;
	logic sclk, cs_n, din, dout, dout_oe_n, sample_switch, balance;
	logic power_down, sel_two, hold_start, busy;
	logic [RESULT_W-1:0] conv_result;
	logic [15:0] rx0, rx1;
	wire dout_pin;
	int n_mismatch = 0;
	int comparisons = 0;
	int run_len = 0;
	int gap = 1000;
	int nap_len = 0;
	int nap_max = 0;

	always #20 clock = ~clock;
	// Pin floats while released
	assign dout_pin = dout_oe_n ? 1'bz : dout;
	// Core stand-in: result tells which input was sampled
	assign conv_result = sel_two ? RES_TWO : RES_ONE;

	dcsf_frame_ctrl dcsf_frame_ctrl_i (.clock(clock), .rst_n(rst_n),
		.clk_en(1'b1), .sclk(sclk), .cs_n(cs_n), .din(din),
		.conv_result(conv_result), .dout(dout), .dout_oe_n(dout_oe_n),
		.sample_switch(sample_switch), .comparator_balance_switch(balance),
		.power_down(power_down), .select_input_two(sel_two),
		.hold_start(hold_start));
	dcsf_host dcsf_host_i (.clock(clock), .go(go), .idle_high(idle_high),
		.n_conv(n_conv), .w0(w0), .w1(w1), .dout_pin(dout_pin),
		.sclk(sclk), .cs_n(cs_n), .din(din), .busy(busy), .rx0(rx0),
		.rx1(rx1));

	// ********************************************************
	// Checking helpers
	// ********************************************************
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Track length, switch pairing and spacing of conversions
	always @(posedge clock) begin
		if (hold_start === 1'b1) begin
			check("track_len", 16'(run_len), 16'h0030);
			check("pd_hold", 16'(power_down), 16'h0000);
			if (gap < 400) begin
				check("conv_gap", 16'(gap), 16'h00ff);
			end
		end
		if (sample_switch !== balance) begin
			check("balance", 16'(balance), 16'(sample_switch));
		end
		run_len <= (sample_switch === 1'b1) ? run_len + 1 : 0;
		gap <= (hold_start === 1'b1) ? 0 : gap + 1;
		// Longest stretch powered down while selected
		nap_len <= (cs_n === 1'b0 && power_down === 1'b1) ?
			nap_len + 1 : 0;
		if (nap_len > nap_max) begin
			nap_max <= nap_len;
		end
	end

	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic frame(input logic hi, input logic [1:0] n,
		input logic [7:0] a, input logic [7:0] b);
		int t;
		t = 0;
		repeat (500) @(negedge clock);
		idle_high = hi;
		n_conv = n;
		w0 = a;
		w1 = b;
		go <= 1'b1;
		repeat (2) @(negedge clock);
		go <= 1'b0;
		while (busy !== 1'b0 && t < 4000) begin
			@(negedge clock);
			t++;
		end
		check("frame_done", 16'(busy), 16'h0000);
	endtask

	task automatic sc_first();
		repeat (3) @(negedge clock);
		check("oe_idle", 16'(dout_oe_n), 16'h0001);
		check("pd_idle", 16'(power_down), 16'h0001);
		frame(1'b0, 2'h2, 8'h08, 8'h08);
		check("conv_a", rx0, {3'h0, RES_ONE, 3'h0});
		check("conv_b", rx1, {3'h0, RES_TWO, 3'h0});
		check("oe_after", 16'(dout_oe_n), 16'h0001);
		check("pd_after", 16'(power_down), 16'h0001);
		check("nap_len", 16'(nap_max), 16'h0010);
	endtask

	// Clock resting high, ignored bits set around a zero low address bit
	task automatic sc_idle_high();
		frame(1'b1, 2'h2, 8'he7, 8'h28);
		check("hi_a", rx0, {3'h0, RES_TWO, 3'h0});
		check("hi_b", rx1, {3'h0, RES_ONE, 3'h0});
	endtask

	// Reset in mid-run returns to input one; top address bit ignored
	task automatic sc_reset();
		@(negedge clock);
		rst_n = 1'b0;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		frame(1'b0, 2'h1, 8'h28, 8'h00);
		check("rst_a", rx0, {3'h0, RES_ONE, 3'h0});
		frame(1'b0, 2'h1, 8'h00, 8'h00);
		check("top_bit", rx0, {3'h0, RES_TWO, 3'h0});
	endtask

	initial begin
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		sc_first();
		sc_idle_high();
		sc_reset();
		summarize();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (50000) @(negedge clock);
		n_mismatch++;
		summarize();
	end
endmodule

`default_nettype wire

// >>> src/dcsf_frame_ctrl.sv
// Serial frame and conversion sequencing of the dual channel converter
// How it works
// - Conversion start to start is 16 clocks
// - Track during first three serial clocks
// - Hold then shift result MSB first, fall four
// - Select frames transfer; output released while high
// - Power down while deselected and between conversions
// - Retrack after N*16 falls, hold at N*16+4
// - Clock gated off; select fall acts as falling
// - Clock resting high: track at first real fall
// - Capture control word on first eight rises
// - Only bit three, the low address bit, matters
// - Low address bit picks input two
// - No warm up; first sample is input one
// - Result is ten bit straight binary
// - Nap from 16th fall to next first
`timescale 1ns/1ps
`default_nettype none

module dcsf_frame_ctrl (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic clk_en, // Freezes all state when low
	input wire logic sclk, // Serial clock pin
	input wire logic cs_n, // Chip select pin, active low
	input wire logic din, // Serial data input pin
	input wire logic [dcsf_pkg::RESULT_W-1:0] conv_result, // Core result
	output logic dout, // Serial data output level
	output logic dout_oe_n, // Output enable, low drives pin
	output logic sample_switch, // Capacitor to input channel
	output logic comparator_balance_switch, // Comparator balanced
	output logic power_down, // Converter powered down
	output logic select_input_two, // Channel mux, 0 input one
	output logic hold_start // Pulse at start of hold
);
	import dcsf_pkg::*;

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		dcsf_phase_t phase;
		logic iclk_prev;
		logic [CNT_W-1:0] fall_cnt;
		logic [CNT_W-1:0] rise_cnt;
		logic [CTRL_W-1:0] ctrl;
		logic chan_next;
		logic chan_cur;
		logic [RESULT_W-1:0] res;
		logic dout;
		logic dout_oe_n;
		logic pdown;
		logic track;
		logic hold_start;
	} dcsf_state_t;

	localparam dcsf_state_t ST_RESET = '{
		phase: PH_IDLE,
		iclk_prev: 1'b1,
		fall_cnt: CNT_RESET,
		rise_cnt: CNT_RESET,
		ctrl: CTRL_RESET,
		chan_next: CHAN_RESET,
		chan_cur: CHAN_RESET,
		res: '0,
		dout: 1'b0,
		dout_oe_n: 1'b1,
		pdown: 1'b1,
		track: 1'b0,
		hold_start: 1'b0
	};

	dcsf_state_t st;
	dcsf_state_t next_st;
	logic [2:0] pins_sync;
	logic sclk_s;
	logic cs_n_s;
	logic din_s;
	logic iclk;
	logic fall_ev;
	logic rise_ev;

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	// Select rests high in reset, so no false frame after release
	dcsf_sync #(
		.W(3),
		.RST_VAL(3'h2)
	) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({sclk, cs_n, din}),
		.sync_out(pins_sync)
	);

	assign sclk_s = pins_sync[2];
	assign cs_n_s = pins_sync[1];
	assign din_s = pins_sync[0];

	// Internal clock held high while deselected
	assign iclk = sclk_s | cs_n_s;
	// Edges only count inside a frame
	assign fall_ev = st.iclk_prev & ~iclk & ~cs_n_s;
	assign rise_ev = ~st.iclk_prev & iclk & ~cs_n_s;

	// ********************************************************
	// Sequencer
	// ********************************************************
	always_comb begin
		next_st = st;
		next_st.hold_start = 1'b0;
		next_st.iclk_prev = iclk;
		if (cs_n_s) begin
			// Deselected: release output, power down
			next_st.phase = PH_IDLE;
			next_st.fall_cnt = CNT_RESET;
			next_st.rise_cnt = CNT_RESET;
			next_st.dout = 1'b0;
			next_st.dout_oe_n = 1'b1;
			next_st.pdown = 1'b1;
			next_st.track = 1'b0;
		end else begin
			next_st.dout_oe_n = 1'b0;
			if (fall_ev) begin
				if (st.phase == PH_IDLE || st.fall_cnt == CONV_EDGES) begin
					// New conversion, word of last one applies
					next_st.phase = PH_TRACK;
					next_st.fall_cnt = FIRST_EDGE;
					next_st.rise_cnt = CNT_RESET;
					next_st.chan_cur = st.chan_next;
					next_st.dout = 1'b0;
					next_st.pdown = 1'b0;
					next_st.track = 1'b1;
				end else begin
					next_st.fall_cnt = st.fall_cnt + FIRST_EDGE;
					if (next_st.fall_cnt == HOLD_EDGE) begin
						// Hold and present the MSB
						next_st.phase = PH_HOLD;
						next_st.track = 1'b0;
						next_st.hold_start = 1'b1;
						next_st.res = conv_result;
						next_st.dout = conv_result[RESULT_W-1];
					end else if (next_st.fall_cnt > HOLD_EDGE &&
					             next_st.fall_cnt <= LAST_BIT_EDGE) begin
						// Shift out on falling edges
						next_st.res = {st.res[RESULT_W-2:0], 1'b0};
						next_st.dout = st.res[RESULT_W-2];
					end else if (next_st.fall_cnt == CONV_EDGES) begin
						// Nap until next first fall
						next_st.phase = PH_NAP;
						next_st.pdown = 1'b1;
						next_st.dout = 1'b0;
					end else begin
						next_st.dout = 1'b0;
					end
				end
			end
			if (rise_ev) begin
				if (st.rise_cnt < CTRL_EDGES) begin
					// Control word taken on rising edges
					next_st.ctrl = {st.ctrl[CTRL_W-2:0], din_s};
					if (st.rise_cnt == CTRL_EDGES - FIRST_EDGE) begin
						// Only the low address bit decides
						next_st.chan_next = next_st.ctrl[CHAN_ADDR_LOW_POS];
					end
				end
				if (st.rise_cnt < CONV_EDGES) begin
					next_st.rise_cnt = st.rise_cnt + FIRST_EDGE;
				end
			end
		end
	end

	// State register, input one after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Outputs straight from state flops
	assign dout = st.dout;
	assign dout_oe_n = st.dout_oe_n;
	assign sample_switch = st.track;
	assign comparator_balance_switch = st.track;
	assign power_down = st.pdown;
	assign select_input_two = st.chan_cur;
	assign hold_start = st.hold_start;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking dcsf_cb @(posedge clock);
	endclocking
	default disable iff (!rst_n || !clk_en);

	// Output released one cycle after deselect
	chk_oe_follows_cs: assert property (
		cs_n_s |=> (st.dout_oe_n && st.dout == 1'b0))
		else $error("output not released while deselected");

	// Power down while deselected
	chk_pdown_deselect: assert property (
		cs_n_s |=> st.pdown && st.phase == PH_IDLE)
		else $error("not powered down while deselected");

	// Conversion start enters track at count one
	chk_track_start: assert property (
		(fall_ev && (st.phase == PH_IDLE || st.fall_cnt == CONV_EDGES))
		|=> (st.phase == PH_TRACK && st.fall_cnt == FIRST_EDGE &&
		     st.track && !st.pdown))
		else $error("conversion did not start in track");

	// Track lasts until the fourth fall
	chk_track_three: assert property (
		(fall_ev && st.fall_cnt == TRACK_EDGES)
		|=> (st.phase == PH_HOLD && !st.track && st.hold_start))
		else $error("hold did not start on fourth fall");

	// MSB of the held result leads the stream
	chk_msb_first: assert property (
		(fall_ev && st.fall_cnt == TRACK_EDGES)
		|=> st.dout == $past(conv_result[RESULT_W-1]))
		else $error("first result bit is not the MSB");

	// Zeros after the last result bit
	chk_zero_pad: assert property (
		(fall_ev && st.fall_cnt >= LAST_BIT_EDGE &&
		 st.fall_cnt < CONV_EDGES) |=> st.dout == 1'b0)
		else $error("trailing output bit not zero");

	// Nap from the sixteenth fall
	chk_nap_after16: assert property (
		(fall_ev && st.fall_cnt == CONV_EDGES - FIRST_EDGE)
		|=> (st.pdown && st.phase == PH_NAP)[*2])
		else $error("no power down after sixteenth fall");

	// Eighth rise loads the channel for the next conversion
	chk_ctrl_capture: assert property (
		(rise_ev && st.rise_cnt == CTRL_EDGES - FIRST_EDGE)
		|=> st.chan_next == $past(st.ctrl[CHAN_ADDR_LOW_POS-1]))
		else $error("channel select not taken from control word");

	// Output level moves only after falls or deselect
	chk_dout_on_fall: assert property (
		$changed(st.dout) |-> ($past(fall_ev) || $past(cs_n_s)))
		else $error("output changed without a falling edge");

	// Channel mux changes only at conversion start
	chk_mux_at_start: assert property (
		$changed(st.chan_cur) |-> $past(fall_ev) && st.phase == PH_TRACK)
		else $error("channel changed outside conversion start");

	cov_two_conv: cover property (
		(fall_ev && st.fall_cnt == CONV_EDGES) ##1 st.phase == PH_TRACK);
	cov_input_two: cover property (
		$rose(st.chan_cur));
	cov_hold: cover property (
		st.hold_start ##[1:200] st.phase == PH_NAP);
	cov_abort: cover property (
		st.phase == PH_HOLD ##1 st.phase == PH_IDLE);

endmodule
`default_nettype wire

// >>> src/dcsf_sync.sv
// Two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none

module dcsf_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic clk_en, // Freezes state when low
	input wire logic [W-1:0] async_in, // Pin levels
	output logic [W-1:0] sync_out // Synchronised levels
);

	typedef struct packed {
		logic [W-1:0] first;
		logic [W-1:0] second;
	} dcsf_sync_t;

	dcsf_sync_t st;
	dcsf_sync_t next_st;

	// ********************************************************
	// Two stages, first read only by second
	// ********************************************************
	always_comb begin
		next_st = st;
		next_st.first = async_in;
		next_st.second = st.first;
	end

	// State register, both stages rest at the pins' idle levels
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{first: RST_VAL, second: RST_VAL};
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign sync_out = st.second;

endmodule
`default_nettype wire
